// [cbda_pkg.sv]
package cbda_pkg;

  // Operation codes presented by the sequencer.
  typedef enum logic [2:0] {
    OP_COMPARE    = 3'b000,
    OP_DEC_CARRY  = 3'b001,
    OP_DEC_ADD    = 3'b010,
    OP_COUNT_DOWN = 3'b011,
    OP_COUNT_DN2  = 3'b100,
    OP_IRQ_DIS    = 3'b101,
    OP_IRQ_EN     = 3'b110,
    OP_NONE       = 3'b111
  } cbda_op_e;

  // One request from the sequencer.
  typedef struct packed {
    cbda_op_e    op;
    logic        byte_mode;
    logic [15:0] src;
    logic [15:0] dst;
  } cbda_req_s;

  // One answer to the register file.
  typedef struct packed {
    logic        done;
    logic        write_dst;
    logic [15:0] data;
  } cbda_rsp_s;

  // Status word bit positions.
  localparam int BIT_C      = 0;
  localparam int BIT_Z      = 1;
  localparam int BIT_N      = 2;
  localparam int BIT_GIE    = 3;
  localparam int BIT_CPU_OFF_BIT = 4;
  localparam int BIT_OSCILLATOR_OFF_BIT = 5;
  localparam int BIT_V      = 8;

  // Masks and reset value of the status word.
  localparam logic [15:0] GIE_MASK = 16'h0008;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [15:0] SW_WMASK = 16'h013f;

  // Register offsets (byte addresses).
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_INFO   = 12'h008;

  // Latency from a taken request to its answer.
  localparam int EXEC_CYCLES = 1;

endpackage : cbda_pkg

// [cbda_core.sv]
`timescale 1ns/1ps

// How it works
// - Compare adds the inverted source plus one to the destination and writes only the flags.
// - Compare sets negative, zero, carry out of the top bit and signed overflow from the difference.
// - Arithmetic operations never touch the oscillator-off, CPU-off or interrupt enable bits.
// - Decimal carry-add adds only the carry and sets carry when 9999 or 99 wraps to zero.
// - Decimal add sums packed BCD digits plus carry into the destination, leaving the source alone.
// - Decimal add sets negative from the top bit, zero on zero and carry past 9999 or 99.
// - Count-down subtracts one, zero only from one, carry cleared only from zero.
// - Count-down sets overflow only from 08000h (word) or 080h (byte).
// - Count-down-two subtracts two, zero only from two, carry cleared only from zero or one.
// - Interrupt disable clears the global enable bit and nothing else.
// - Interrupt enable sets the global enable bit and nothing else.
// - Clearing the enable may not block an interrupt already sampled by the sequencer.
// - After an interrupt enable the next instruction always runs before any interrupt.
module cbda_core
  import cbda_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sequencer request.
  input  wire logic        exec_valid,
  input  wire cbda_req_s   exec_req,
  output logic             exec_ready,
  input  wire logic        insn_retire,
  // Answer to the register file.
  output cbda_rsp_s        exec_rsp,
  output logic      [15:0] status_word,
  output logic             irq_allow
);

  // Adds a and b with carry in; returns {v, c, result}.
  function automatic logic [17:0] add_flags(input logic [15:0] a, input logic [15:0] b,
                                            input logic cin, input logic bm);
    logic [16:0] s;
    logic        v;
    s = 17'h00000;
    v = 1'b0;
    if (bm)
    begin
      s[8:0] = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
      v = (a[7] == b[7]) && (s[7] != a[7]);
      return {v, s[8], 8'h00, s[7:0]};
    end
    s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    v = (a[15] == b[15]) && (s[15] != a[15]);
    return {v, s[16], s[15:0]};
  endfunction : add_flags

  // Packed BCD add; returns {carry, result}. Non-BCD digits give no defined sum.
  function automatic logic [16:0] bcd_add(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin, input logic bm);
    logic [4:0]  t;
    logic        c;
    logic [15:0] r;
    c = cin;
    r = 16'h0000;
    t = 5'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (!bm || i < 2)
      begin
        t = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
        c = (t > 5'h09);
        r[i*4 +: 4] = c ? 4'(t - 5'h0a) : t[3:0];
      end
    end
    return {c, r};
  endfunction : bcd_add

  // Top bit of a result for the width in use.
  function automatic logic msb_of(input logic [15:0] r, input logic bm);
    return bm ? r[7] : r[15];
  endfunction : msb_of

  logic        take;
  logic        apb_acc;
  logic        sw_wr;
  logic [15:0] next_sw;
  logic [15:0] next_res;
  logic        next_wr;
  logic [17:0] arith;
  logic [16:0] bcd;
  logic [15:0] res_hold;
  logic        irq_enable_op_shadow;
  cbda_req_s   req_q;
  logic [15:0] sw_before;

  // A status write from software waits while an instruction completes.
  assign apb_acc    = psel && penable;
  assign sw_wr      = apb_acc && pwrite && (paddr == OFS_STATUS);
  assign pready     = !(sw_wr && exec_valid);
  assign exec_ready = 1'b1;
  assign take       = exec_valid;

  // Result and flag computation for one request.
  always_comb
  begin
    next_sw  = status_word;
    next_res = exec_req.dst;
    next_wr  = 1'b0;
    arith    = 18'h00000;
    bcd      = 17'h00000;
    unique case (exec_req.op)
      OP_COMPARE:
      begin
        arith = add_flags(exec_req.dst, ~exec_req.src, 1'b1, exec_req.byte_mode);
        next_sw[BIT_N] = msb_of(arith[15:0], exec_req.byte_mode);
        next_sw[BIT_Z] = (arith[15:0] == 16'h0000);
        next_sw[BIT_C] = arith[16];
        next_sw[BIT_V] = arith[17];
      end
      OP_DEC_CARRY, OP_DEC_ADD:
      begin
        bcd = bcd_add(exec_req.dst, (exec_req.op == OP_DEC_ADD) ? exec_req.src : 16'h0000,
                      status_word[BIT_C], exec_req.byte_mode);
        next_res = bcd[15:0];
        next_wr  = 1'b1;
        // BCD flags, overflow left as is
        next_sw[BIT_N] = msb_of(bcd[15:0], exec_req.byte_mode);
        next_sw[BIT_Z] = (bcd[15:0] == 16'h0000);
        next_sw[BIT_C] = bcd[16];
      end
      OP_COUNT_DOWN, OP_COUNT_DN2:
      begin
        arith = add_flags(exec_req.dst, (exec_req.op == OP_COUNT_DOWN) ? 16'hfffe : 16'hfffd,
                          1'b1, exec_req.byte_mode);
        next_res = arith[15:0];
        next_wr  = 1'b1;
        next_sw[BIT_N] = msb_of(arith[15:0], exec_req.byte_mode);
        next_sw[BIT_Z] = (arith[15:0] == 16'h0000);
        next_sw[BIT_C] = arith[16];
        next_sw[BIT_V] = arith[17];
      end
      OP_IRQ_DIS:
        next_sw = status_word & ~GIE_MASK;
      OP_IRQ_EN:
        next_sw = status_word | GIE_MASK;
      OP_NONE:
        next_sw = status_word;
    endcase
    if (exec_req.op != OP_IRQ_DIS && exec_req.op != OP_IRQ_EN)
      next_sw[BIT_GIE] = status_word[BIT_GIE];
  end

  // Status word: instruction completion, else a software write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_word <= SW_RESET;
    else if (take)
      status_word <= next_sw;
    else if (sw_wr)
      status_word <= pwdata[15:0] & SW_WMASK;
  end

  // Answer to the register file, one cycle after the request.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_rsp <= '0;
      res_hold <= 16'h0000;
    end
    else
    begin
      exec_rsp.done      <= take;
      exec_rsp.write_dst <= take && next_wr;
      exec_rsp.data      <= take ? next_res : exec_rsp.data;
      res_hold           <= (take && next_wr) ? next_res : res_hold;
    end
  end

  // Last request and the status it saw; op and byte mode are read back, the rest serve the checks.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q     <= '{op: OP_NONE, byte_mode: 1'b0, src: 16'h0000, dst: 16'h0000};
      sw_before <= SW_RESET;
    end
    else if (take)
    begin
      req_q     <= exec_req;
      sw_before <= status_word;
    end
  end

  // Holds off interrupts until one more instruction has finished.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable_op_shadow <= 1'b0;
    else if (take && exec_req.op == OP_IRQ_EN)
      irq_enable_op_shadow <= 1'b1;
    else if (insn_retire || take)
      irq_enable_op_shadow <= 1'b0;
  end

  // no early block
  // An interrupt already sampled by the sequencer before the disable completes still runs.
  assign irq_allow = status_word[BIT_GIE] && !irq_enable_op_shadow;

  // Register read path; unmapped addresses answer with an error.
  always_comb
  begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    if (apb_acc)
    begin
      unique case (paddr)
        OFS_STATUS: prdata = {16'h0000, status_word};
        OFS_RESULT: prdata = {16'h0000, res_hold};
        OFS_INFO:   prdata = {27'h0000000, irq_enable_op_shadow, req_q.byte_mode, req_q.op};
        default:    pslverr = 1'b1;
      endcase
    end
  end

  // Checks on completed operations.
  sequence s_done(cbda_op_e o);
    exec_rsp.done && req_q.op == o;
  endsequence

  sequence s_word_done(cbda_op_e o);
    s_done(o) ##0 !req_q.byte_mode;
  endsequence

  a_cmp_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_COMPARE) |-> !exec_rsp.write_dst)
    else $error("compare wrote its destination");

  a_cmp_carry_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_COMPARE) |-> status_word[BIT_C] == (req_q.dst >= req_q.src)
      && status_word[BIT_Z] == (req_q.dst == req_q.src))
    else $error("compare carry or zero wrong");

  a_mode_bits_kept: assert property (@(posedge pclk) disable iff (!presetn)
    exec_rsp.done && req_q.op inside {OP_COMPARE, OP_DEC_CARRY, OP_DEC_ADD, OP_COUNT_DOWN, OP_COUNT_DN2}
      |-> status_word[5:3] == sw_before[5:3])
    else $error("mode bits changed by arithmetic");

  a_bcd_wrap_carry: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_DEC_CARRY) ##0 (req_q.dst == 16'h9999 && sw_before[BIT_C])
      |-> exec_rsp.data == 16'h0000 && status_word[BIT_C] && status_word[BIT_Z])
    else $error("decimal carry wrap wrong");

  a_bcd_low_digit: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_DEC_ADD) ##0 (req_q.dst[3:0] + req_q.src[3:0] + sw_before[BIT_C] < 10)
      |-> exec_rsp.write_dst && exec_rsp.data[3:0] == 4'(req_q.dst[3:0] + req_q.src[3:0] + sw_before[BIT_C]))
    else $error("decimal low digit wrong");

  a_bcd_flags: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_DEC_ADD) |-> status_word[BIT_N] == exec_rsp.data[15]
      && status_word[BIT_Z] == (exec_rsp.data == 16'h0000))
    else $error("decimal add flags wrong");

  a_dec_zero_carry: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_COUNT_DOWN) |->
      status_word[BIT_Z] == (req_q.byte_mode ? req_q.dst[7:0] == 8'h01 : req_q.dst == 16'h0001)
      && status_word[BIT_C] == (req_q.byte_mode ? req_q.dst[7:0] != 8'h00 : req_q.dst != 16'h0000))
    else $error("count-down zero or carry wrong");

  a_dec_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_COUNT_DOWN) |-> status_word[BIT_V]
      == (req_q.byte_mode ? req_q.dst[7:0] == 8'h80 : req_q.dst == 16'h8000))
    else $error("count-down overflow wrong");

  a_dec2_carry: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_COUNT_DN2) |-> status_word[BIT_C] == (req_q.dst > 16'h0001)
      && status_word[BIT_Z] == (req_q.dst == 16'h0002))
    else $error("count-down-two carry or zero wrong");

  a_dec2_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_COUNT_DN2) |-> status_word[BIT_V] == (req_q.dst[15:1] == 15'h4000))
    else $error("count-down-two overflow wrong");

  a_dec2_byte: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_COUNT_DN2) ##0 req_q.byte_mode |->
      status_word[BIT_Z] == (req_q.dst[7:0] == 8'h02)
      && status_word[BIT_C] == (req_q.dst[7:1] != 7'h00))
    else $error("byte count-down-two zero or carry wrong");

  a_dis_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_IRQ_DIS) |-> status_word == (sw_before & ~GIE_MASK) && !irq_allow)
    else $error("interrupt disable wrong");

  a_en_sets: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_IRQ_EN) |-> status_word == (sw_before | GIE_MASK))
    else $error("interrupt enable wrong");

  a_en_holds_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_done(OP_IRQ_EN) |-> !irq_allow)
    else $error("interrupt allowed right after enable");

  // The shadow may wait any number of idle cycles; only a retire or a new instruction ends it.
  a_shadow_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    irq_enable_op_shadow && !insn_retire && !exec_valid |=> !irq_allow)
    else $error("interrupt allowed before the next instruction");

  a_flags_with_done: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(status_word) |-> exec_rsp.done || $past(sw_wr))
    else $error("status changed without completion");

  // Difference of the last request, worked out separately for the compare flag checks.
  logic [15:0] chk_diff;
  assign chk_diff = req_q.dst - req_q.src;

  a_cmp_sign_over: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_done(OP_COMPARE) |-> status_word[BIT_N] == chk_diff[15]
      && status_word[BIT_V] == ((req_q.dst[15] != req_q.src[15]) && (chk_diff[15] != req_q.dst[15])))
    else $error("compare sign or overflow wrong");

  a_byte_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    exec_rsp.write_dst && req_q.byte_mode |-> exec_rsp.data[15:8] == 8'h00)
    else $error("byte result high byte not zero");

  a_sw_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    sw_wr && pready |=> status_word == ($past(pwdata[15:0]) & SW_WMASK))
    else $error("software status write lost");

endmodule : cbda_core

// [cbda_seq_model.sv]
`timescale 1ns/1ps

// Sequencer stand-in: offers one request at a time and a retire pulse.
module cbda_seq_model
  import cbda_pkg::*;
(
  // Clock.
  input  wire logic pclk,
  // Exec port.
  output logic      exec_valid,
  output cbda_req_s exec_req,
  output logic      insn_retire
);
  // Idle levels at time zero.
  initial
  begin
    exec_valid  = 1'b0;
    exec_req    = '0;
    insn_retire = 1'b0;
  end

  // The payload is scrambled once released, so a stale request is never mistaken for a live one.
  task automatic issue(input cbda_req_s q);
    @(posedge pclk);
    exec_valid <= 1'b1;
    exec_req   <= q;
    @(posedge pclk);
    exec_valid <= 1'b0;
    exec_req   <= ~q;
  endtask : issue

  // One-cycle pulse for another instruction completing.
  task automatic retire();
    @(posedge pclk);
    insn_retire <= 1'b1;
    @(posedge pclk);
    insn_retire <= 1'b0;
  endtask : retire
endmodule : cbda_seq_model

// [compare_bcd_decrement_alu_tb_top.sv]
`timescale 1ns/1ps

module compare_bcd_decrement_alu_tb_top
  import cbda_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        exec_valid, insn_retire, irq_allow, er, exec_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] status_word, exp_sw, last_res;
  cbda_req_s   exec_req, q;
  cbda_rsp_s   exec_rsp;
  int          miscompares, checks_done, cycles, waits;

  cbda_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_valid(exec_valid), .exec_req(exec_req), .exec_ready(exec_ready), .insn_retire(insn_retire),
    .exec_rsp(exec_rsp), .status_word(status_word), .irq_allow(irq_allow));

  cbda_seq_model seq (.pclk(pclk), .exec_valid(exec_valid), .exec_req(exec_req), .insn_retire(insn_retire));

  // Free-running 25 MHz clock.
  always #20 pclk = ~pclk;

  // A hung handshake ends the run as a failure.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  // Read data and error are taken at the edge where pready is seen high; waits counts the stalls.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      waits++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_sw(input logic [15:0] v);
    apb(1'b1, OFS_STATUS, {16'h0, v});
    exp_sw = v & SW_WMASK;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word("status read", {16'h0, exp_sw}, rd);
  endtask : set_sw

  // Expected {write_dst, status, result} worked out digit by digit or by two's complement.
  function automatic logic [32:0] expect_op(input logic [15:0] sw, input cbda_req_s r);
    logic [16:0] a;
    logic [15:0] d, s, res;
    logic [4:0]  t;
    logic        c, v;
    d = r.byte_mode ? {8'h00, r.dst[7:0]} : r.dst;
    s = (r.op == OP_COUNT_DOWN) ? 16'h0001 : (r.op == OP_COUNT_DN2) ? 16'h0002 : r.src;
    if (r.op == OP_DEC_CARRY)
      s = 16'h0000;
    if (r.byte_mode)
      s[15:8] = 8'h00;
    if (r.op == OP_NONE)
      return {1'b0, sw, 16'h0000};
    if (r.op == OP_IRQ_DIS || r.op == OP_IRQ_EN)
      return {1'b0, (r.op == OP_IRQ_EN) ? (sw | GIE_MASK) : (sw & ~GIE_MASK), 16'h0000};
    c = sw[BIT_C];
    v = sw[BIT_V];
    res = 16'h0000;
    if (r.op == OP_DEC_CARRY || r.op == OP_DEC_ADD)
      for (int i = 0; i < (r.byte_mode ? 8 : 16); i += 4)
      begin
        t = d[i+:4] + s[i+:4] + c;
        c = (t > 5'd9);
        res[i+:4] = c ? t[3:0] + 4'h6 : t[3:0];
      end
    else
    begin
      d = r.byte_mode ? d << 8 : d;
      s = r.byte_mode ? s << 8 : s;
      a = {1'b0, d} + {1'b0, ~s} + 17'h00001;
      c = a[16];
      v = (d[15] != s[15]) && (a[15] != d[15]);
      res = r.byte_mode ? {8'h00, a[15:8]} : a[15:0];
    end
    sw[BIT_C] = c;
    sw[BIT_Z] = (res == 16'h0000);
    sw[BIT_N] = r.byte_mode ? res[7] : res[15];
    sw[BIT_V] = v;
    return {r.op != OP_COMPARE, sw, res};
  endfunction : expect_op

  task automatic run(input cbda_req_s r);
    logic [32:0] e;
    e = expect_op(exp_sw, r);
    seq.issue(r);
    #1;
    chk_bit("done", 1'b1, exec_rsp.done);
    chk_bit("exec_ready", 1'b1, exec_ready);
    chk_bit("write_dst", e[32], exec_rsp.write_dst);
    if (e[32])
      chk_word("result", {16'h0, e[15:0]}, {16'h0, exec_rsp.data});
    if (e[32])
      last_res = e[15:0];
    chk_word("status_word", {16'h0, e[31:16]}, {16'h0, status_word});
    exp_sw = e[31:16];
  endtask : run

  task automatic corner(input cbda_op_e op, input logic bm, input logic [15:0] s, d, sw);
    set_sw(sw);
    run('{op, bm, s, d});
  endtask : corner

  function automatic logic [15:0] rand_bcd();
    for (int i = 0; i < 16; i += 4)
      rand_bcd[i+:4] = 4'($urandom_range(9));
  endfunction : rand_bcd

  // Main sequence: reset, corner cases, random traffic, then bus refusals.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    exp_sw = SW_RESET;
    last_res = 16'h0000;
    void'($urandom(32'h2b7e680e));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk_word("reset status", {16'h0, SW_RESET}, {16'h0, status_word});
    corner(OP_COMPARE, 1'b0, 16'h1234, 16'h1234, 16'h0000);
    corner(OP_COMPARE, 1'b1, 16'h0001, 16'h0080, 16'h0038);
    corner(OP_COUNT_DOWN, 1'b0, 16'h0, 16'h0001, 16'h0000);
    corner(OP_COUNT_DOWN, 1'b0, 16'h0, 16'h0000, 16'h0001);
    corner(OP_COUNT_DOWN, 1'b0, 16'h0, 16'h8000, 16'h0000);
    corner(OP_COUNT_DOWN, 1'b1, 16'h0, 16'h0080, 16'h0000);
    corner(OP_COUNT_DN2, 1'b0, 16'h0, 16'h0002, 16'h0000);
    corner(OP_COUNT_DN2, 1'b0, 16'h0, 16'h0001, 16'h0001);
    corner(OP_COUNT_DN2, 1'b0, 16'h0, 16'h8001, 16'h0000);
    corner(OP_COUNT_DN2, 1'b1, 16'h0, 16'h0081, 16'h0000);
    corner(OP_DEC_CARRY, 1'b0, 16'h0, 16'h9999, 16'h0001);
    corner(OP_DEC_CARRY, 1'b1, 16'h0, 16'h0099, 16'h0031);
    corner(OP_DEC_ADD, 1'b1, 16'h0001, 16'h0099, 16'h0000);
    corner(OP_IRQ_DIS, 1'b0, 16'h0, 16'h0, 16'h013f);
    corner(OP_NONE, 1'b0, 16'h1234, 16'h5678, 16'h0107);
    corner(OP_IRQ_EN, 1'b0, 16'h0, 16'h0, 16'h0137);
    chk_bit("irq_allow shadow", 1'b0, irq_allow);
    seq.retire();
    #1;
    chk_bit("irq_allow", 1'b1, irq_allow);
    repeat (300)
    begin
      q.op = cbda_op_e'($urandom_range(6));
      q.byte_mode = 1'($urandom_range(1));
      q.src = (q.op == OP_DEC_ADD) ? rand_bcd() : 16'($urandom);
      q.dst = (q.op inside {OP_DEC_ADD, OP_DEC_CARRY}) ? rand_bcd() : 16'($urandom);
      if ($urandom_range(7) == 0)
        set_sw(16'($urandom));
      run(q);
    end
    apb(1'b0, OFS_INFO, 32'h0);
    chk_word("info reg", {27'h0, q.op == OP_IRQ_EN, q.byte_mode, q.op}, rd);
    apb(1'b1, OFS_RESULT, 32'hffffffff);
    apb(1'b0, OFS_RESULT, 32'h0);
    chk_word("result reg", {16'h0, last_res}, rd);
    apb(1'b1, 12'h0fc, 32'h0);
    chk_bit("pslverr", 1'b1, er);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word("status kept", {16'h0, exp_sw}, rd);
    // A completing instruction wins over a status write, which then stalls one cycle and lands after it.
    set_sw(16'h0000);
    fork
      apb(1'b1, OFS_STATUS, 32'h00000125);
      begin
        @(posedge pclk);
        seq.issue('{OP_COMPARE, 1'b0, 16'h0001, 16'h0002});
      end
    join
    chk_word("collision waits", 32'h00000001, waits);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word("status after collision", 32'h00000125, rd);
    final_report();
  end
endmodule : compare_bcd_decrement_alu_tb_top
